// file: ppfc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppfc_core_model #(
  parameter int LANES = 4
) (
  input wire logic clk_i,
  output logic read_clock_o = 1'b0,
  output logic write_clock_o = 1'b0,
  output logic read_enable_n_o = 1'b1,
  output logic write_enable_n_o = 1'b1,
  output logic clear_n_o = 1'b1,
  output logic [LANES-1:0] write_bit_o = '0
);
  // Every level is held at least two cycles, or the pin sampler could miss it.
  task automatic xfer(input logic wr, input logic [LANES-1:0] d, input int gap);
    @(posedge clk_i);
    write_enable_n_o <= !wr;
    read_enable_n_o <= wr;
    write_bit_o <= d;
    repeat (gap) @(posedge clk_i);
    write_clock_o <= wr;
    read_clock_o <= !wr;
    repeat (gap) @(posedge clk_i);
    write_clock_o <= 1'b0;
    read_clock_o <= 1'b0;
    write_enable_n_o <= 1'b1;
    read_enable_n_o <= 1'b1;
    write_bit_o <= ~d;
    repeat (gap + 2) @(posedge clk_i);
  endtask
  task automatic clear();
    @(posedge clk_i);
    clear_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    clear_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: ppfc_pkg.sv
package ppfc_pkg;
  localparam int PPFC_DEPTH = 64;
  localparam int PPFC_PTR_W = 7;
  localparam int PPFC_THR_W = 6;
  localparam int PPFC_LANES = 26;

  localparam logic [3:0] PPFC_OFF_CTRL = 4'h0;
  localparam logic [3:0] PPFC_OFF_THRESH = 4'h4;
  localparam logic [3:0] PPFC_OFF_STATUS = 4'h8;

  localparam int PPFC_CTRL_MODE_LSB = 0;
  localparam int PPFC_CTRL_DDR_BIT = 2;
  localparam int PPFC_CTRL_DIFF_BIT = 3;
  localparam int PPFC_THR_AF_LSB = 0;
  localparam int PPFC_THR_AE_LSB = 8;
  localparam int PPFC_ST_EMPTY_BIT = 0;
  localparam int PPFC_ST_FULL_BIT = 1;
  localparam int PPFC_ST_AE_BIT = 2;
  localparam int PPFC_ST_AF_BIT = 3;
  localparam int PPFC_ST_COUNT_LSB = 4;

  localparam logic [31:0] PPFC_CTRL_RESET = 32'h0000_0000;
  localparam logic [5:0] PPFC_AF_RESET = 6'h30;
  localparam logic [5:0] PPFC_AE_RESET = 6'h10;

  localparam logic [1:0] PPFC_MODE_BYPASS = 2'h0;
  localparam logic [1:0] PPFC_MODE_INPUT = 2'h1;
  localparam logic [1:0] PPFC_MODE_OUTPUT = 2'h2;
endpackage

// file: ppfc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ppfc_properties #(
  parameter int LANES = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic write_enable_n_i,
  input wire logic clear_n_i,
  input wire logic [LANES/2-1:0] rise_edge_output_o,
  input wire logic block_read_enable_out_n_o,
  input wire logic block_write_enable_out_n_o,
  input wire logic block_clear_n_o,
  input wire logic empty_flag_o,
  input wire logic full_flag_o,
  input wire logic almost_empty_flag_o,
  input wire logic almost_full_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_clear_held;
    !clear_n_i [*6];
  endsequence
  property p_bus_ack;
    s_req |=> s_ack;
  endproperty
  property p_full_af;
    full_flag_o |-> almost_full_flag_o;
  endproperty
  property p_empty_ae;
    empty_flag_o |-> almost_empty_flag_o;
  endproperty
  property p_flags_excl;
    !(empty_flag_o && full_flag_o);
  endproperty
  property p_full_blocks;
    full_flag_o && $past(full_flag_o) |-> block_write_enable_out_n_o;
  endproperty
  property p_empty_blocks;
    empty_flag_o && $past(empty_flag_o) |-> block_read_enable_out_n_o;
  endproperty
  property p_clear_flags;
    s_clear_held |-> !block_clear_n_o && !full_flag_o && !almost_full_flag_o && empty_flag_o;
  endproperty
  property p_clear_data;
    s_clear_held |-> rise_edge_output_o == '0;
  endproperty
  property p_wen_cause;
    !block_write_enable_out_n_o |-> !$past(write_enable_n_i, 2) || !$past(write_enable_n_i, 3)
      || !$past(write_enable_n_i, 4);
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus ack missing or too long");
  a_full_af: assert property (p_full_af) else $error("full without almost full");
  a_empty_ae: assert property (p_empty_ae) else $error("empty without almost empty");
  a_flags_excl: assert property (p_flags_excl) else $error("empty and full together");
  a_full_blocks: assert property (p_full_blocks) else $error("write passed while full");
  a_empty_blocks: assert property (p_empty_blocks) else $error("read passed while empty");
  a_clear_flags: assert property (p_clear_flags) else $error("clear did not reset flags");
  a_clear_data: assert property (p_clear_data) else $error("clear left output data");
  a_wen_cause: assert property (p_wen_cause) else $error("block write enable without cause");
endmodule
bind ppfc_top ppfc_properties #(.LANES(LANES)) u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .write_enable_n_i, .clear_n_i, .rise_edge_output_o, .block_read_enable_out_n_o, .block_write_enable_out_n_o,
  .block_clear_n_o, .empty_flag_o, .full_flag_o, .almost_empty_flag_o, .almost_full_flag_o);
`default_nettype wire

// file: ppfc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppfc_tb_top;
  import ppfc_pkg::*;
  localparam int LANES = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [LANES-1:0] pad_in_i = 4'h6;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, read_clock_i, write_clock_i, read_enable_n_i, write_enable_n_i, clear_n_i;
  logic [LANES-1:0] write_bit_i, read_bit_o, pad_out_o, pad_oe_o;
  logic [LANES/2-1:0] rise_edge_output_o, fall_edge_output_o;
  logic block_read_enable_out_n_o, block_write_enable_out_n_o, block_clear_n_o;
  logic empty_flag_o, full_flag_o, almost_empty_flag_o, almost_full_flag_o;
  int n_mismatch = 0;
  int comparisons = 0;
  always #10 clk_i = ~clk_i;
  ppfc_top #(.LANES(LANES)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .read_clock_i, .write_clock_i, .read_enable_n_i, .write_enable_n_i,
    .clear_n_i, .write_bit_i, .pad_in_i, .read_bit_o, .pad_out_o, .pad_oe_o, .rise_edge_output_o,
    .fall_edge_output_o, .block_read_enable_out_n_o, .block_write_enable_out_n_o, .block_clear_n_o,
    .empty_flag_o, .full_flag_o, .almost_empty_flag_o, .almost_full_flag_o);
  ppfc_core_model #(.LANES(LANES)) u_core (.clk_i, .read_clock_o(read_clock_i), .write_clock_o(write_clock_i),
    .read_enable_n_o(read_enable_n_i), .write_enable_n_o(write_enable_n_i), .clear_n_o(clear_n_i),
    .write_bit_o(write_bit_i));
  task automatic tally_and_finish();
    $display("Counts: comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // Thresholds sit at the extremes: almost full at 63, almost empty at 1.
  task automatic st(input int c);
    logic [31:0] q;
    logic [31:0] e;
    e = {21'h0, 7'(c), 1'(c >= 63), 1'(c <= 1), 1'(c == 64), 1'(c == 0)};
    wb(1'b0, PPFC_OFF_STATUS, 32'h0, q);
    chk("status", e, q);
    chk("flag pins", {28'h0, e[3:0]}, {28'h0, almost_full_flag_o, almost_empty_flag_o, full_flag_o, empty_flag_o});
  endtask
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, PPFC_OFF_THRESH, 32'h0, q);
    chk("thresh reset", {16'h0, 2'h0, PPFC_AE_RESET, 2'h0, PPFC_AF_RESET}, q);
    wb(1'b1, PPFC_OFF_THRESH, 32'h0000_013F, q);
    wb(1'b0, PPFC_OFF_THRESH, 32'h0, q);
    chk("thresh", 32'h0000_013F, q);
    wb(1'b1, 4'hC, 32'hFFFF_FFFF, q);
    wb(1'b0, 4'hC, 32'h0, q);
    chk("unmapped", 32'h0, q);
    wb(1'b1, PPFC_OFF_STATUS, 32'hFFFF_FFFF, q);
    st(0);
    $display("t_regs done");
  endtask
  task automatic t_modes();
    logic [31:0] q;
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, PPFC_OFF_CTRL, 32'(m), q);
      wb(1'b0, PPFC_OFF_CTRL, 32'h0, q);
      chk("ctrl", 32'(m), q);
      if (m != 0) begin
        chk("pad enable", {28'h0, {LANES{m == 2}}}, 32'(pad_oe_o));
      end
    end
    $display("t_modes done");
  endtask
  task automatic t_flow();
    for (int k = 0; k < 64; k++) begin
      u_core.xfer(1'b1, 4'(k) ^ 4'h5, 2);
      st(k + 1);
    end
    u_core.xfer(1'b1, 4'hF, 2);
    st(64);
    for (int k = 0; k < 64; k++) begin
      u_core.xfer(1'b0, 4'h0, 5);
      st(63 - k);
      chk("queue out", 32'(4'(k) ^ 4'h5), 32'(pad_out_o));
    end
    u_core.xfer(1'b0, 4'h0, 2);
    st(0);
    chk("queue out held", 32'hA, 32'(pad_out_o));
    $display("t_flow done");
  endtask
  task automatic t_clear();
    for (int k = 0; k < 3; k++) begin
      u_core.xfer(1'b1, 4'h9, 2);
    end
    u_core.clear();
    st(0);
    chk("data after clear", 32'h0, 32'(pad_out_o));
    u_core.xfer(1'b1, 4'h6, 2);
    u_core.xfer(1'b0, 4'h0, 2);
    chk("word after clear", 32'h6, 32'(pad_out_o));
    $display("t_clear done");
  endtask
  // Pads hold 4'h6; a double-rate word takes its odd lanes at the falling write edge.
  task automatic t_paths();
    logic [31:0] q;
    logic [31:0] ddr_ctrl;
    ddr_ctrl = 32'(PPFC_MODE_INPUT) | (32'h1 << PPFC_CTRL_DDR_BIT);
    wb(1'b1, PPFC_OFF_CTRL, 32'(PPFC_MODE_INPUT), q);
    u_core.xfer(1'b1, 4'h0, 2);
    u_core.xfer(1'b0, 4'h0, 2);
    chk("input word", 32'h6, 32'(read_bit_o));
    chk("rise out", 32'h2, 32'(rise_edge_output_o));
    chk("fall out", 32'h1, 32'(fall_edge_output_o));
    wb(1'b1, PPFC_OFF_CTRL, ddr_ctrl, q);
    u_core.xfer(1'b1, 4'h0, 2);
    u_core.xfer(1'b0, 4'h0, 2);
    chk("single rise", 32'h2, 32'(rise_edge_output_o));
    chk("single fall", 32'h2, 32'(fall_edge_output_o));
    st(0);
    wb(1'b1, PPFC_OFF_CTRL, ddr_ctrl | (32'h1 << PPFC_CTRL_DIFF_BIT), q);
    u_core.xfer(1'b1, 4'h0, 2);
    u_core.xfer(1'b0, 4'h0, 2);
    chk("diff rise", 32'h2, 32'(rise_edge_output_o));
    chk("diff fall", 32'h1, 32'(fall_edge_output_o));
    wb(1'b1, PPFC_OFF_CTRL, 32'(PPFC_MODE_BYPASS), q);
    pad_in_i <= 4'h9;
    repeat (4) @(posedge clk_i);
    chk("bypass in", 32'h9, 32'(read_bit_o));
    chk("bypass out", 32'(write_bit_i), 32'(pad_out_o));
    $display("t_paths done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_modes();
    t_flow();
    t_clear();
    t_paths();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: ppfc_top.sv
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Each lane owns a 64-deep one-bit queue with separate read and write clocks.
// - Queue path is selectable: pad input, pad output, or bypassed.
// - One to 26 lanes share common enables and clear from one controller.
// - Active-low clear zeroes output data and both pointers.
// - Read enable before a read clock rise outputs current bit, then advances.
// - Write enable before a write clock rise stores input bit, then advances.
// - Controller drives empty, full, almost-empty and almost-full with user thresholds.
// - Writes are blocked while full, reads while empty.
// - Controller clear resets the full and almost-full flags.
// - Usage count changes on each enabled read clock rise.
// - Usage count increments on each enabled write clock rise.
// - Controller drives block read and write enables to every governed queue.
// - Controller drives an active-low block clear to every governed queue.
// - Thresholds are six-bit unsigned absolute positions from 0 to 63.
// - Full flag is one when all 64 positions are occupied.
// - Almost-full flag is one when count reaches or exceeds its threshold.
// - Empty flag is one when count is zero.
// - Almost-empty flag is one when count is at or below its threshold.
// - DDR gives a rising-edge queue output and a falling-edge queue output.
// - All queues come out of reset with pointers cleared.
module ppfc_top
  import ppfc_pkg::*;
#(
  parameter int LANES = PPFC_LANES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic read_clock_i,
  input wire logic write_clock_i,
  input wire logic read_enable_n_i,
  input wire logic write_enable_n_i,
  input wire logic clear_n_i,
  input wire logic [LANES-1:0] write_bit_i,
  input wire logic [LANES-1:0] pad_in_i,
  output logic [LANES-1:0] read_bit_o,
  output logic [LANES-1:0] pad_out_o,
  output logic [LANES-1:0] pad_oe_o,
  output logic [LANES/2-1:0] rise_edge_output_o,
  output logic [LANES/2-1:0] fall_edge_output_o,
  output logic block_read_enable_out_n_o,
  output logic block_write_enable_out_n_o,
  output logic block_clear_n_o,
  output logic empty_flag_o,
  output logic full_flag_o,
  output logic almost_empty_flag_o,
  output logic almost_full_flag_o
);
  localparam int SW = 5 + 2 * LANES;

  function automatic logic [PPFC_PTR_W-1:0] gray2bin(input logic [PPFC_PTR_W-1:0] g);
    logic [PPFC_PTR_W-1:0] b;
    b[PPFC_PTR_W-1] = g[PPFC_PTR_W-1];
    for (int i = PPFC_PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Pin-side inputs: two flops, then a third stage only for clock edge detection.
  // The samplers reset to the idle pin levels: enables and clear high, clocks low.
  // Resetting them to zero would fake a write enable and a clear for two cycles after reset.
  localparam logic [SW-1:0] SYNC_IDLE = {2'h0, 3'h7, {(2 * LANES){1'h0}}};
  logic [SW-1:0] sync1;
  logic [SW-1:0] next_sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] next_sync2;
  logic [1:0] clk3;
  logic [1:0] next_clk3;
  always_comb begin
    next_sync1 = {read_clock_i, write_clock_i, read_enable_n_i, write_enable_n_i, clear_n_i, write_bit_i, pad_in_i};
    next_sync2 = sync1;
    next_clk3 = sync2[SW-1 -: 2];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
      clk3 <= 2'h0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      clk3 <= next_clk3;
    end
  end

  logic rclk_s;
  logic wclk_s;
  logic ren_n_s;
  logic wen_n_s;
  logic clr_n_s;
  logic [LANES-1:0] wbit_s;
  logic [LANES-1:0] pad_s;
  logic rd_rise;
  logic wr_rise;
  logic wr_fall;
  assign {rclk_s, wclk_s, ren_n_s, wen_n_s, clr_n_s, wbit_s, pad_s} = sync2;
  assign rd_rise = rclk_s & ~clk3[1];
  assign wr_rise = wclk_s & ~clk3[0];
  assign wr_fall = ~wclk_s & clk3[0];

  // Software-visible configuration.
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic ddr;
  logic next_ddr;
  logic diff;
  logic next_diff;
  logic [5:0] af_thr;
  logic [5:0] next_af_thr;
  logic [5:0] ae_thr;
  logic [5:0] next_ae_thr;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // Queue state.
  logic [PPFC_PTR_W-1:0] wgray;
  logic [PPFC_PTR_W-1:0] next_wgray;
  logic [PPFC_PTR_W-1:0] rgray;
  logic [PPFC_PTR_W-1:0] next_rgray;
  logic [LANES-1:0] qdata;
  logic [LANES-1:0] next_qdata;
  logic fall_pend;
  logic next_fall_pend;
  logic [LANES-1:0] mem [PPFC_DEPTH];
  logic mem_we;
  logic [5:0] mem_addr;
  logic [LANES-1:0] mem_mask;
  logic [LANES-1:0] mem_data;
  logic [LANES-1:0] lane_src;

  logic [PPFC_PTR_W-1:0] wptr;
  logic [PPFC_PTR_W-1:0] rptr;
  logic [PPFC_PTR_W-1:0] count;
  logic do_wr;
  logic do_rd;
  logic is_full;
  logic is_empty;
  assign wptr = gray2bin(wgray);
  assign rptr = gray2bin(rgray);
  assign count = wptr - rptr;
  assign is_full = (count == PPFC_PTR_W'(PPFC_DEPTH));
  assign is_empty = (count == '0);
  assign do_wr = wr_rise & ~wen_n_s & ~is_full & clr_n_s;
  assign do_rd = rd_rise & ~ren_n_s & ~is_empty & clr_n_s;

  // Flags and block outputs.
  logic f_empty;
  logic next_f_empty;
  logic f_full;
  logic next_f_full;
  logic f_ae;
  logic next_f_ae;
  logic f_af;
  logic next_f_af;
  logic b_ren_n;
  logic next_b_ren_n;
  logic b_wen_n;
  logic next_b_wen_n;
  logic b_clr_n;
  logic next_b_clr_n;
  logic [LANES-1:0] rbit;
  logic [LANES-1:0] next_rbit;
  logic [LANES-1:0] pout;
  logic [LANES-1:0] next_pout;
  logic [LANES-1:0] poe;
  logic [LANES-1:0] next_poe;

  always_comb begin
    next_mode = mode;
    next_ddr = ddr;
    next_diff = diff;
    next_af_thr = af_thr;
    next_ae_thr = ae_thr;
    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    next_rdata = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !ack) begin
      if (wb_we_i) begin
        if (wb_adr_i == PPFC_OFF_CTRL && wb_sel_i[0]) begin
          next_mode = wb_dat_i[PPFC_CTRL_MODE_LSB +: 2];
          next_ddr = wb_dat_i[PPFC_CTRL_DDR_BIT];
          next_diff = wb_dat_i[PPFC_CTRL_DIFF_BIT];
        end
        if (wb_adr_i == PPFC_OFF_THRESH) begin
          if (wb_sel_i[0]) begin
            next_af_thr = wb_dat_i[PPFC_THR_AF_LSB +: PPFC_THR_W];
          end
          if (wb_sel_i[1]) begin
            next_ae_thr = wb_dat_i[PPFC_THR_AE_LSB +: PPFC_THR_W];
          end
        end
      end else begin
        unique case (wb_adr_i)
          PPFC_OFF_CTRL: begin
            next_rdata[PPFC_CTRL_MODE_LSB +: 2] = mode;
            next_rdata[PPFC_CTRL_DDR_BIT] = ddr;
            next_rdata[PPFC_CTRL_DIFF_BIT] = diff;
          end
          PPFC_OFF_THRESH: begin
            next_rdata[PPFC_THR_AF_LSB +: PPFC_THR_W] = af_thr;
            next_rdata[PPFC_THR_AE_LSB +: PPFC_THR_W] = ae_thr;
          end
          PPFC_OFF_STATUS: begin
            next_rdata[PPFC_ST_EMPTY_BIT] = f_empty;
            next_rdata[PPFC_ST_FULL_BIT] = f_full;
            next_rdata[PPFC_ST_AE_BIT] = f_ae;
            next_rdata[PPFC_ST_AF_BIT] = f_af;
            next_rdata[PPFC_ST_COUNT_LSB +: PPFC_PTR_W] = count;
          end
          default: next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Lane sources: the odd lane of a DDR pair takes the negative leg only when differential.
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      lane_src[i] = (mode == PPFC_MODE_INPUT) ? pad_s[i] : wbit_s[i];
      if (ddr && i[0] && mode == PPFC_MODE_INPUT) begin
        lane_src[i] = diff ? pad_s[i] : pad_s[i-1];
      end
    end
  end

  always_comb begin
    next_wgray = wgray;
    next_rgray = rgray;
    next_qdata = qdata;
    next_fall_pend = fall_pend;
    mem_we = 1'b0;
    mem_addr = wptr[5:0];
    mem_data = lane_src;
    mem_mask = '1;
    if (ddr) begin
      for (int i = 0; i < LANES; i++) begin
        mem_mask[i] = ~i[0];
      end
    end
    if (!clr_n_s) begin
      next_wgray = '0;
      next_rgray = '0;
      next_qdata = '0;
      next_fall_pend = 1'b0;
    end else begin
      if (do_wr) begin
        mem_we = 1'b1;
        next_wgray = (wptr + 1'b1) ^ ((wptr + 1'b1) >> 1);
        next_fall_pend = ddr;
      end else if (ddr && fall_pend && wr_fall) begin
        // Falling-edge half of the pair lands in the word the rising edge just filled.
        mem_we = 1'b1;
        mem_addr = 6'(wptr - 1'b1);
        mem_mask = ~mem_mask;
        next_fall_pend = 1'b0;
      end
      if (do_rd) begin
        next_qdata = mem[rptr[5:0]];
        next_rgray = (rptr + 1'b1) ^ ((rptr + 1'b1) >> 1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_addr] <= (mem[mem_addr] & ~mem_mask) | (mem_data & mem_mask);
    end
  end

  always_comb begin
    logic [PPFC_PTR_W-1:0] nc;
    nc = gray2bin(next_wgray) - gray2bin(next_rgray);
    next_f_empty = (nc == '0);
    next_f_full = (nc == PPFC_PTR_W'(PPFC_DEPTH));
    next_f_af = (nc >= {1'b0, af_thr});
    next_f_ae = (nc <= {1'b0, ae_thr});
    if (!clr_n_s) begin
      next_f_full = 1'b0;
      next_f_af = 1'b0;
    end
    next_b_ren_n = ren_n_s | is_empty;
    next_b_wen_n = wen_n_s | is_full;
    next_b_clr_n = clr_n_s;
    for (int i = 0; i < LANES; i++) begin
      next_rbit[i] = (mode == PPFC_MODE_INPUT) ? next_qdata[i] : pad_s[i];
      next_pout[i] = (mode == PPFC_MODE_OUTPUT) ? next_qdata[i] : wbit_s[i];
      next_poe[i] = (mode != PPFC_MODE_INPUT);
    end
  end

  // Power-up reset leaves every queue empty with both pointers at zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= PPFC_CTRL_RESET[PPFC_CTRL_MODE_LSB +: 2];
      ddr <= PPFC_CTRL_RESET[PPFC_CTRL_DDR_BIT];
      diff <= PPFC_CTRL_RESET[PPFC_CTRL_DIFF_BIT];
      af_thr <= PPFC_AF_RESET;
      ae_thr <= PPFC_AE_RESET;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      wgray <= '0;
      rgray <= '0;
      qdata <= '0;
      fall_pend <= 1'b0;
      f_empty <= 1'b1;
      f_full <= 1'b0;
      f_ae <= 1'b1;
      f_af <= 1'b0;
      b_ren_n <= 1'b1;
      b_wen_n <= 1'b1;
      b_clr_n <= 1'b0;
      rbit <= '0;
      pout <= '0;
      poe <= '0;
    end else begin
      mode <= next_mode;
      ddr <= next_ddr;
      diff <= next_diff;
      af_thr <= next_af_thr;
      ae_thr <= next_ae_thr;
      ack <= next_ack;
      rdata <= next_rdata;
      wgray <= next_wgray;
      rgray <= next_rgray;
      qdata <= next_qdata;
      fall_pend <= next_fall_pend;
      f_empty <= next_f_empty;
      f_full <= next_f_full;
      f_ae <= next_f_ae;
      f_af <= next_f_af;
      b_ren_n <= next_b_ren_n;
      b_wen_n <= next_b_wen_n;
      b_clr_n <= next_b_clr_n;
      rbit <= next_rbit;
      pout <= next_pout;
      poe <= next_poe;
    end
  end

  always_comb begin
    for (int k = 0; k < LANES / 2; k++) begin
      rise_edge_output_o[k] = qdata[2*k];
      fall_edge_output_o[k] = qdata[2*k+1];
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign read_bit_o = rbit;
  assign pad_out_o = pout;
  assign pad_oe_o = poe;
  assign block_read_enable_out_n_o = b_ren_n;
  assign block_write_enable_out_n_o = b_wen_n;
  assign block_clear_n_o = b_clr_n;
  assign empty_flag_o = f_empty;
  assign full_flag_o = f_full;
  assign almost_empty_flag_o = f_ae;
  assign almost_full_flag_o = f_af;
endmodule
`default_nettype wire
